//--- rtl/hspc_pkg.sv
/*
 * Package for the hub sideband pin control block: port count, strap
 * layout, interrupt modes and the packed structs that group the pins.
 * Assumes nothing of its surroundings beyond a single system clock.
 */
package hspc_pkg;

    // ------------------------------------------------------------------
    // Port layout
    // ------------------------------------------------------------------
    localparam int unsigned HSPC_NUM_PORTS     = 3;  // Downstream ports
    localparam int unsigned HSPC_NUM_STRAPPED  = 2;  // Ports 1 and 2 only
    localparam int unsigned HSPC_SYNC_STAGES   = 3;  // Pin synchroniser depth

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [HSPC_NUM_PORTS-1:0] HSPC_DISABLE_RST = 3'h0;
    localparam logic                      HSPC_PIN_HIGH    = 1'h1;
    localparam logic                      HSPC_PIN_LOW     = 1'h0;

    // Interrupt pin function
    typedef enum logic [0:0] {
        HSPC_MODE_GENERAL = 1'b0,  // Event interrupt
        HSPC_MODE_SUSPEND = 1'b1   // Suspend indicator
    } hspc_mode_e;

    // Strap state machine
    typedef enum logic [1:0] {
        HSPC_ST_STANDBY = 2'b00,   // Chip reset asserted
        HSPC_ST_SETTLE  = 2'b01,   // Waiting for synchronisers to fill
        HSPC_ST_RUN     = 2'b10    // Straps latched
    } hspc_state_e;

    // Downstream data pin pair of every port
    typedef struct packed {
        logic [HSPC_NUM_PORTS-1:0] plus_line;   // D+ per port
        logic [HSPC_NUM_PORTS-1:0] minus_line;  // D- per port
    } hspc_dn_pins_s;

    // Hub state that drives the interrupt pin
    typedef struct packed {
        logic status_update;   // Pulse: enabled status register updated
        logic status_cleared;  // Pulse: host wrote interrupt status reg
        logic configured;      // Hub configured by host
        logic suspended;       // Hub in USB suspend
    } hspc_hub_state_s;

endpackage : hspc_pkg

//--- rtl/hspc_top.sv
/*
 * Sideband pin logic of a three-port hub: port disable straps, the
 * active-low interrupt pin, over-current sense and port power request.
 * Assumes pins arrive asynchronous to i_clk_sys and that the hub core
 * supplies status events and suspend state on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - Sample strappable port data pins at reset release
// - Port disabled only if both pins high
// - Port 3 has no disable strap
// - General mode: status update drives interrupt low
// - Host clear of status returns interrupt high
// - Suspend mode: high when configured and active
// - Low over-current sense means fault reported
// - Port power output high requests power
// - Chip reset low holds device in standby
module hspc_top
    import hspc_pkg::*;
#(
    parameter int unsigned NUM_PORTS = HSPC_NUM_PORTS,     // Port count
    parameter int unsigned NUM_STRAP = HSPC_NUM_STRAPPED   // Strapped ports
) (
    input  wire logic                 i_clk_sys,           // 100 MHz clock
    input  wire logic                 i_reset,             // Sync, high
    input  wire logic                 i_chip_reset_n,      // Chip reset pin
    input  wire hspc_dn_pins_s        i_dn_pins,           // Data pin pairs
    input  wire logic                 i_interrupt_mode_select, // Mode bit
    input  wire hspc_hub_state_s      i_hub_state,         // Hub core state
    input  wire logic                 i_overcurrent_sense_low, // Pin, low
    input  wire logic                 i_port_power_on,     // Core request
    output logic [NUM_PORTS-1:0]      o_port_disable,      // Strap result
    output logic                      o_standby,           // Held in reset
    output logic                      o_overcurrent_fault, // Fault seen
    output logic                      o_interrupt_n,       // Interrupt pin
    output logic                      o_port_power_request // Power pin
);

    // ------------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------------
    if (NUM_PORTS != HSPC_NUM_PORTS || NUM_STRAP >= NUM_PORTS) begin : g_chk
        $error("hspc_top: unsupported port or strap count");
    end

    localparam int unsigned PW = 2 * NUM_PORTS + 2;  // Synchronised width
    localparam int unsigned IX_RST = PW - 1;         // Chip reset bit
    localparam int unsigned IX_OCS = PW - 2;         // Over-current bit

    // Idle levels of the pin bundle: chip reset asserted, no over-current,
    // data pins low. Resetting the chain to all zero would let a
    // false fault ripple through once i_reset drops.
    localparam logic [PW-1:0] SYNC_RST = PW'(HSPC_PIN_HIGH) << IX_OCS;

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    logic [PW-1:0] sync1_r;   // First stage, read only by stage two
    logic [PW-1:0] sync2_r;   // Second stage
    logic [PW-1:0] sync3_r;   // Third stage
    logic [PW-1:0] clean_r;   // Accepted level once stages 2 and 3 agree
    logic [PW-1:0] pins_raw;  // Raw pin bundle

    assign pins_raw = {i_chip_reset_n, i_overcurrent_sense_low,
                       i_dn_pins.plus_line, i_dn_pins.minus_line};

    // Three-stage chain; all pins are asynchronous to the system clock
    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            sync1_r <= SYNC_RST;  // Idle pin levels, not all zero
            sync2_r <= SYNC_RST;
            sync3_r <= SYNC_RST;
        end else begin
            sync1_r <= pins_raw;
            sync2_r <= sync1_r;
            sync3_r <= sync2_r;
        end
    end

    // Per-bit filter: a change counts only when stages two and three agree
    for (genvar b = 0; b < PW; b++) begin : g_filt
        // Reset levels: chip reset asserted, no over-current, pins low
        localparam logic RST_V = SYNC_RST[b];
        always_ff @(posedge i_clk_sys) begin
            if (i_reset) begin
                clean_r[b] <= RST_V;
            end else if (sync2_r[b] == sync3_r[b]) begin
                clean_r[b] <= sync3_r[b];
            end
        end
    end

    logic                 chip_rst_n;  // Filtered chip reset, high = run
    logic [NUM_PORTS-1:0] dp_clean;    // Filtered D+ pins
    logic [NUM_PORTS-1:0] dm_clean;    // Filtered D- pins

    assign chip_rst_n = clean_r[IX_RST];
    assign dp_clean   = clean_r[NUM_PORTS +: NUM_PORTS];
    assign dm_clean   = clean_r[0 +: NUM_PORTS];

    // ------------------------------------------------------------------
    // Standby and strap capture
    // ------------------------------------------------------------------
    hspc_state_e state_r;    // Strap sequencer state
    hspc_state_e state_nxt;  // Next state

    // Settle costs one cycle so the straps sampled at release are the
    // levels that were stable while reset was held
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            HSPC_ST_STANDBY: begin
                if (chip_rst_n) begin
                    state_nxt = HSPC_ST_SETTLE;  // Release seen
                end
            end
            HSPC_ST_SETTLE: begin
                state_nxt = chip_rst_n ? HSPC_ST_RUN : HSPC_ST_STANDBY;
            end
            HSPC_ST_RUN: begin
                if (!chip_rst_n) begin
                    state_nxt = HSPC_ST_STANDBY; // Back to standby
                end
            end
            default: begin
                state_nxt = HSPC_ST_STANDBY;
            end
        endcase
    end

    // State register
    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            state_r <= HSPC_ST_STANDBY;
        end else begin
            state_r <= state_nxt;
        end
    end

    logic [NUM_PORTS-1:0] disable_r;    // Latched strap result
    logic [NUM_PORTS-1:0] disable_nxt;  // Strap evaluation

    // Both lines high disables; ports above the strapped range never
    always_comb begin
        disable_nxt = HSPC_DISABLE_RST;
        for (int p = 0; p < NUM_STRAP; p++) begin
            disable_nxt[p] = dp_clean[p] & dm_clean[p];
        end
        // Port 3 bit stays clear whatever its pins show
    end

    // Capture on release, then hold until the next release
    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            disable_r <= HSPC_DISABLE_RST;
        end else if (state_r == HSPC_ST_STANDBY && chip_rst_n) begin
            disable_r <= disable_nxt;
        end
        // Otherwise hold across run and standby
    end

    logic standby_r;  // Device held in low-power standby

    // Standby is high whenever the next sequencer state is not run
    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            standby_r <= HSPC_PIN_HIGH;
        end else begin
            standby_r <= (state_nxt != HSPC_ST_RUN);
        end
    end

    // ------------------------------------------------------------------
    // Interrupt pin
    // ------------------------------------------------------------------
    logic event_r;  // Sticky general event, cleared by host write

    // Set wins over a clear in the same cycle so no event is lost
    always_ff @(posedge i_clk_sys) begin
        if (i_reset || standby_r) begin
            event_r <= HSPC_PIN_LOW;
        end else if (i_hub_state.status_update) begin
            event_r <= HSPC_PIN_HIGH;
        end else if (i_hub_state.status_cleared) begin
            event_r <= HSPC_PIN_LOW;
        end
    end

    logic int_n_r;  // Registered interrupt pin level

    // Mode select picks event or suspend indication
    always_ff @(posedge i_clk_sys) begin
        if (i_reset || standby_r) begin
            int_n_r <= HSPC_PIN_HIGH;  // Negated while in standby
        end else if (i_interrupt_mode_select == HSPC_MODE_SUSPEND) begin
            // High only when configured and not suspended
            int_n_r <= i_hub_state.configured & ~i_hub_state.suspended;
        end else begin
            // Low while an event waits; pulse-to-level is one cycle
            int_n_r <= ~(event_r | i_hub_state.status_update);
        end
    end

    // ------------------------------------------------------------------
    // Over-current sense and port power
    // ------------------------------------------------------------------
    logic oc_fault_r;  // Registered fault flag
    logic pwr_r;       // Registered power request

    // Low sense level is a fault; power dropped in standby
    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            oc_fault_r <= HSPC_PIN_LOW;
            pwr_r      <= HSPC_PIN_LOW;
        end else begin
            oc_fault_r <= ~clean_r[IX_OCS];
            pwr_r      <= i_port_power_on & ~standby_r;
        end
    end

    assign o_port_disable       = disable_r;
    assign o_standby            = standby_r;
    assign o_overcurrent_fault  = oc_fault_r;
    assign o_interrupt_n        = int_n_r;
    assign o_port_power_request = pwr_r;

endmodule : hspc_top

`default_nettype wire

//--- verification/hspc_checker.sv
/* Assertions on the sideband pin block's ports.
   Assumes binding into hspc_top on its one clock. */
`timescale 1ns/1ps
`default_nettype none
module hspc_checker
    import hspc_pkg::*;
#(parameter int unsigned NUM_PORTS = 3) (
    input wire logic                 i_clk_sys,
    input wire logic                 i_reset,
    input wire logic                 i_chip_reset_n,
    input wire logic                 i_interrupt_mode_select,
    input wire hspc_hub_state_s      i_hub_state,
    input wire logic                 i_overcurrent_sense_low,
    input wire logic                 i_port_power_on,
    input wire logic [NUM_PORTS-1:0] o_port_disable,
    input wire logic                 o_standby,
    input wire logic                 o_overcurrent_fault,
    input wire logic                 o_interrupt_n,
    input wire logic                 o_port_power_request
);
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (i_reset);
    // Running, pin released; mode history checked in each assertion, not in the covers
    logic gen, sus, act;
    assign gen = !o_standby && !i_interrupt_mode_select && i_chip_reset_n;
    assign sus = !o_standby && i_interrupt_mode_select && i_chip_reset_n;
    assign act = i_hub_state.configured && !i_hub_state.suspended;
    gen_set_a: assert property (gen && $past(gen)
        && i_hub_state.status_update |=> !o_interrupt_n)
        else $error("interrupt not raised");
    gen_clr_a: assert property ((gen && $past(gen)
        && i_hub_state.status_cleared && !i_hub_state.status_update)
        ##1 (gen && !i_hub_state.status_update) |=> o_interrupt_n)
        else $error("interrupt not released");
    sus_low_a: assert property (sus && $past(sus) && !act
        |=> !o_interrupt_n) else $error("suspend pin not low");
    sus_high_a: assert property (sus && $past(sus) && act
        |=> o_interrupt_n) else $error("suspend pin not high");
    pwr_req_a: assert property (!o_standby && $past(!o_standby)
        |-> o_port_power_request == $past(i_port_power_on))
        else $error("power request wrong");
    stby_pins_a: assert property (o_standby && $past(o_standby)
        |-> o_interrupt_n && !o_port_power_request)
        else $error("standby pins wrong");
    strap_hold_a: assert property (!o_standby && $past(!o_standby)
        |-> $stable(o_port_disable)) else $error("straps moved");
    port3_open_a: assert property (!o_port_disable[NUM_PORTS-1])
        else $error("port 3 disabled");
    fault_seen_a: assert property (
        (!i_overcurrent_sense_low && !o_standby)[*6] |-> o_overcurrent_fault)
        else $error("fault missed");
    chip_rel_a: assert property (i_chip_reset_n[*8] |=> !o_standby)
        else $error("standby not left");
    cover property (gen && i_hub_state.status_update);
    cover property (sus && !i_hub_state.configured);
    cover property (o_port_disable[0] && o_port_disable[1]);
endmodule : hspc_checker
bind hspc_top hspc_checker #(.NUM_PORTS(NUM_PORTS)) i_hspc_checker (
    .i_clk_sys, .i_reset, .i_chip_reset_n, .i_interrupt_mode_select,
    .i_hub_state, .i_overcurrent_sense_low, .i_port_power_on,
    .o_port_disable, .o_standby, .o_overcurrent_fault, .o_interrupt_n,
    .o_port_power_request);
`default_nettype wire

//--- verification/hspc_power_switch.sv
/* Model of the external power switch and current monitor.
   Assumes the bench commands an overload through i_short. */
`timescale 1ns/1ps
`default_nettype none
module hspc_power_switch (
    input  wire logic i_port_power_request,    // High asks for power
    input  wire logic i_short,                 // Commanded overload
    output logic      o_overcurrent_sense_low  // Low reports a fault
);
    // Trips only on a powered, shorted load, as a real monitor would
    assign o_overcurrent_sense_low = !(i_port_power_request && i_short);
endmodule : hspc_power_switch
`default_nettype wire

//--- verification/hspc_top_tb_top.sv
/* Testbench for hspc_top: straps, interrupt pin, power and fault.
   Assumes the power switch model on the far side of the power pins. */
`timescale 1ns/1ps
`default_nettype none
module hspc_top_tb_top;
    import hspc_pkg::*;
    logic            clk = 1'h0, rst = 1'h1, chip_n = 1'h0, mode = 1'h0;
    logic            pwr_on, short_c, overcurrent_sense_low, stby, flt, int_n, preq;
    logic [2:0]      dis;          // Strap result
    hspc_dn_pins_s   pins;         // Data pin pairs
    hspc_hub_state_s hub;          // Hub core state
    int              fails = 0, checks = 0, cyc = 0;
    always #5 clk = ~clk;
    hspc_top i_hspc_top (.i_clk_sys(clk), .i_reset(rst),
        .i_chip_reset_n(chip_n), .i_dn_pins(pins),
        .i_interrupt_mode_select(mode), .i_hub_state(hub),
        .i_overcurrent_sense_low(overcurrent_sense_low), .i_port_power_on(pwr_on),
        .o_port_disable(dis), .o_standby(stby), .o_overcurrent_fault(flt),
        .o_interrupt_n(int_n), .o_port_power_request(preq));
    hspc_power_switch i_hspc_power_switch (.i_port_power_request(preq),
        .i_short(short_c), .o_overcurrent_sense_low(overcurrent_sense_low));
    task automatic chk(string what, logic [2:0] exp, logic [2:0] got);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic tick(int n);
        repeat (n) @(negedge clk);
    endtask : tick
    // Hold chip reset, release, wait for straps to land
    task automatic chip_cycle(logic [2:0] p, logic [2:0] m);
        int k;
        pins = {p, m};
        chip_n = 1'h0;
        tick(8);
        chk("standby", 3'h1, {2'h0, stby});
        chk("int in standby", 3'h1, {2'h0, int_n});
        chk("power in standby", 3'h0, {2'h0, preq});
        chip_n = 1'h1;
        k = 0;
        while (stby !== 1'h0 && k < 20) begin
            tick(1);
            k++;
        end
        chk("standby left", 3'h0, {2'h0, stby});
        chk("port disable", p & m & 3'h3, dis);
    endtask : chip_cycle
    task automatic t_strap();
        chip_cycle(3'h2, 3'h5);
        chip_cycle(3'h5, 3'h3);
        chip_cycle(3'h7, 3'h7);
        pins = {3'h0, 3'h0};
        tick(10);
        chk("straps held", 3'h3, dis);
        $display("test strap done");
    endtask : t_strap
    task automatic t_general();
        mode = 1'h0;
        hub.status_cleared = 1'h1;
        tick(1);
        hub.status_cleared = 1'h0;
        tick(2);
        chk("idle clear", 3'h1, {2'h0, int_n});
        hub.status_update = 1'h1;
        tick(1);
        hub.status_update = 1'h0;
        chk("int set", 3'h0, {2'h0, int_n});
        hub.status_update = 1'h1;
        hub.status_cleared = 1'h1;
        tick(1);
        hub = '0;
        tick(3);
        chk("set wins", 3'h0, {2'h0, int_n});
        hub.status_cleared = 1'h1;
        tick(1);
        hub.status_cleared = 1'h0;
        tick(1);
        chk("int clear", 3'h1, {2'h0, int_n});
        $display("test general done");
    endtask : t_general
    task automatic t_suspend();
        mode = 1'h1;
        for (int i = 0; i < 4; i++) begin
            hub.configured = i[0];
            hub.suspended = i[1];
            tick(2);
            chk("suspend pin", {2'h0, i[0] & ~i[1]},
                {2'h0, int_n});
        end
        $display("test suspend done");
    endtask : t_suspend
    task automatic t_power();
        pwr_on = 1'h1;
        tick(2);
        chk("power on", 3'h1, {2'h0, preq});
        chk("no fault", 3'h0, {2'h0, flt});
        short_c = 1'h1;
        tick(8);
        chk("fault", 3'h1, {2'h0, flt});
        pwr_on = 1'h0;
        tick(2);
        chk("power off", 3'h0, {2'h0, preq});
        tick(8);
        chk("fault gone", 3'h0, {2'h0, flt});
        short_c = 1'h0;
        $display("test power done");
    endtask : t_power
    // Pending event and power request meet a chip reset
    task automatic t_standby();
        mode = 1'h0;
        pwr_on = 1'h1;
        hub.status_update = 1'h1;
        tick(1);
        hub.status_update = 1'h0;
        chip_cycle(3'h0, 3'h0);
        tick(2);
        chk("event dropped", 3'h1, {2'h0, int_n});
        chk("power back", 3'h1, {2'h0, preq});
        $display("test standby done");
    endtask : t_standby
    task automatic print_verdict();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : print_verdict
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            fails++;
            print_verdict();
        end
    end
    initial begin
        pins = '0;
        hub = '0;
        pwr_on = 1'h0;
        short_c = 1'h0;
        tick(10);
        rst = 1'h0;
        tick(3);
        chk("fault after reset", 3'h0, {2'h0, flt});
        t_strap();
        t_general();
        t_suspend();
        t_power();
        t_standby();
        print_verdict();
    end
endmodule : hspc_top_tb_top
`default_nettype wire
